// *** core/graphics_dram_timing_ctrl.sv ***
// Purpose: row/column, output enable and write strobes for a 4-row dram array
// Assumes: all inputs synchronous to i_sys_clk; the clock is the dot clock
// Notes:   strobes are registered, active low, inactive between cycles
// Function
// - latch strobe fall: row strobe, address latch
// - word clock rise: switch to column address
// - row bits 0-7, column bits 8-13
// - next tap A rise: common column strobe
// - bits 14-15 pick one column strobe
// - row strobe to all rows always
// - tap C rise after column: output enable
// - output enable only display or rmw
// - one shared output enable for rows
// - latch strobe rise ends every cycle
// - read gate rise drops output enable
// - write strobe: read gate two tap C
// - timing from binary dot clock divider
// - one of four planes per access
// - display fetches refresh the array
`timescale 1ns/100ps
`default_nettype none
module graphics_dram_timing_ctrl #(
	parameter int unsigned DIV_WIDTH = dram_timing_pkg::DIV_WIDTH
) (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_sys_rst,
	// display controller
	input  wire logic        i_ale,
	input  wire logic [15:0] i_ad,
	input  wire logic        i_read_gate_n,
	input  wire logic        i_video_off,
	// memory array
	output logic             o_ras_n,
	output logic             o_row_col_select,
	output logic [7:0]       o_mem_addr,
	output logic             o_col_strobe_common_n,
	output logic [3:0]       o_cas_n,
	output logic             o_oe_n,
	output logic             o_we_n
);

	logic [DIV_WIDTH-1:0] tap;
	logic [DIV_WIDTH-1:0] tap_rise;
	logic                 word_rise;
	logic                 a_rise;
	logic                 c_rise;

	dot_divider #(
		.WIDTH (DIV_WIDTH)
	) u_div (
		.i_sys_clk  (i_sys_clk),
		.i_sys_rst  (i_sys_rst),
		.o_tap      (tap),
		.o_tap_rise (tap_rise)
	);

	assign word_rise = tap_rise[dram_timing_pkg::TAP_WORD];
	assign a_rise    = tap_rise[dram_timing_pkg::TAP_A];
	assign c_rise    = tap_rise[dram_timing_pkg::TAP_C];

	function automatic logic [3:0] decode_cas(input logic enable, input logic [1:0] sel);
		decode_cas = enable ? ~(4'h1 << sel) : dram_timing_pkg::CAS_IDLE;
	endfunction

	// sequence state
	dram_timing_pkg::seq_state_e state;
	dram_timing_pkg::seq_state_e next_state;
	logic                        ale_prev;
	logic                        next_ale_prev;
	logic [15:0]                 bus_lat;
	logic [15:0]                 next_bus_lat;
	logic                        ale_fall;

	assign ale_fall = ale_prev & ~i_ale;

	always_comb begin
		next_state    = state;
		next_bus_lat  = bus_lat;
		next_ale_prev = i_ale;
		if (i_ale) begin
			next_state = dram_timing_pkg::S_IDLE;
		end else begin
			unique case (state)
				dram_timing_pkg::S_IDLE: begin
					if (ale_fall) begin
						next_state   = dram_timing_pkg::S_ROW;
						next_bus_lat = i_ad;
					end
				end
				dram_timing_pkg::S_ROW: begin
					if (word_rise) begin
						next_state = dram_timing_pkg::S_COL;
					end
				end
				dram_timing_pkg::S_COL: begin
					if (a_rise) begin
						next_state = dram_timing_pkg::S_CAS;
					end
				end
				dram_timing_pkg::S_CAS: begin
					if (c_rise) begin
						next_state = dram_timing_pkg::S_DATA;
					end
				end
				dram_timing_pkg::S_DATA: begin
					next_state = dram_timing_pkg::S_DATA;
				end
				default: begin
					next_state = dram_timing_pkg::S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			state    <= dram_timing_pkg::S_IDLE;
			ale_prev <= 1'b1;
			bus_lat  <= dram_timing_pkg::BUS_RST;
		end else begin
			state    <= next_state;
			ale_prev <= next_ale_prev;
			bus_lat  <= next_bus_lat;
		end
	end

	// read gate tracking and write delay
	logic                                   rg_seen;
	logic                                   next_rg_seen;
	logic                                   oe_done;
	logic                                   next_oe_done;
	logic [dram_timing_pkg::WE_DELAY-1:0]   we_sh;
	logic [dram_timing_pkg::WE_DELAY-1:0]   next_we_sh;
	logic                                   in_cycle;

	assign in_cycle = (next_state != dram_timing_pkg::S_IDLE);

	always_comb begin
		next_rg_seen = 1'b0;
		next_oe_done = 1'b0;
		next_we_sh   = '0;
		if (in_cycle) begin
			// no status tells rmw from refresh, so the read gate itself marks it
			next_rg_seen = rg_seen | ~i_read_gate_n;
			next_oe_done = oe_done | (rg_seen & i_read_gate_n);
			next_we_sh   = we_sh;
			if (c_rise) begin
				next_we_sh = {we_sh[dram_timing_pkg::WE_DELAY-2:0], next_rg_seen};
			end
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			rg_seen <= 1'b0;
			oe_done <= 1'b0;
			we_sh   <= '0;
		end else begin
			rg_seen <= next_rg_seen;
			oe_done <= next_oe_done;
			we_sh   <= next_we_sh;
		end
	end

	// registered strobes
	logic       next_ras_n;
	logic       next_rcs;
	logic [7:0] next_mem_addr;
	logic       next_ccs_n;
	logic [3:0] next_cas_n;
	logic       next_oe_n;
	logic       next_we_n;
	logic       col_phase;
	logic       cas_phase;

	always_comb begin
		col_phase = (next_state == dram_timing_pkg::S_COL) ||
			(next_state == dram_timing_pkg::S_CAS) ||
			(next_state == dram_timing_pkg::S_DATA);
		cas_phase = (next_state == dram_timing_pkg::S_CAS) ||
			(next_state == dram_timing_pkg::S_DATA);
		// every row sees the row strobe; selection is by column strobe only
		next_ras_n = ~in_cycle;
		next_rcs   = ~col_phase;
		if (col_phase) begin
			next_mem_addr = {2'b00,
				next_bus_lat[dram_timing_pkg::COL_MSB:dram_timing_pkg::COL_LSB]};
		end else if (ale_fall) begin
			next_mem_addr = i_ad[dram_timing_pkg::ROW_MSB:dram_timing_pkg::ROW_LSB];
		end else begin
			next_mem_addr = o_mem_addr;
		end
		next_ccs_n = ~cas_phase;
		next_cas_n = decode_cas(cas_phase,
			next_bus_lat[dram_timing_pkg::SEL_MSB:dram_timing_pkg::SEL_LSB]);
		// blank with read gate idle means refresh: output enable stays high
		next_oe_n = ~((next_state == dram_timing_pkg::S_DATA) && !next_oe_done &&
			(!i_video_off || !i_read_gate_n));
		next_we_n = ~(in_cycle && next_we_sh[dram_timing_pkg::WE_DELAY-1]);
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			o_ras_n               <= 1'b1;
			o_row_col_select      <= 1'b1;
			o_mem_addr            <= dram_timing_pkg::ADDR_RST;
			o_col_strobe_common_n <= 1'b1;
			o_cas_n               <= dram_timing_pkg::CAS_IDLE;
			o_oe_n                <= 1'b1;
			o_we_n                <= 1'b1;
		end else begin
			o_ras_n               <= next_ras_n;
			o_row_col_select      <= next_rcs;
			o_mem_addr            <= next_mem_addr;
			o_col_strobe_common_n <= next_ccs_n;
			o_cas_n               <= next_cas_n;
			o_oe_n                <= next_oe_n;
			o_we_n                <= next_we_n;
		end
	end

	// checks
	ras_on_fall_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		($fell(i_ale) && state == dram_timing_pkg::S_IDLE) |=>
			(!o_ras_n && o_row_col_select && o_mem_addr == $past(i_ad[7:0])))
		else $error("row strobe or row address missing after latch strobe fall");

	mux_on_word_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(state == dram_timing_pkg::S_ROW && word_rise && !i_ale) |=>
			(!o_row_col_select && o_mem_addr == {2'b00, bus_lat[13:8]}))
		else $error("column address not presented on word clock rise");

	cas_after_mux_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(state == dram_timing_pkg::S_COL && a_rise && !i_ale) |=>
			(!o_col_strobe_common_n && !o_row_col_select && !o_ras_n))
		else $error("common column strobe late or out of order");

	one_row_cas_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		!o_col_strobe_common_n |-> (o_cas_n == ~(4'h1 << bus_lat[15:14])))
		else $error("column strobe decode does not match latched select bits");

	oe_after_cas_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		!o_oe_n |-> (!o_col_strobe_common_n && !o_ras_n))
		else $error("output enable without column strobe");

	refresh_oe_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		!o_oe_n |-> (!$past(i_video_off) || !$past(i_read_gate_n)))
		else $error("output enable driven on a refresh cycle");

	end_cycle_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		i_ale |=> (o_ras_n && o_row_col_select && o_cas_n == 4'hF && o_oe_n && o_we_n))
		else $error("strobes not released by latch strobe rise");

	read_end_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		($rose(i_read_gate_n) && rg_seen && !i_ale) |=> o_oe_n [*2])
		else $error("output enable held after read gate rise");

	we_rmw_only_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		!o_we_n |-> (rg_seen && !o_ras_n))
		else $error("write strobe without read gate in this cycle");

	we_delay_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		($fell(o_we_n)) |-> ($past(c_rise) && $past(we_sh[0])))
		else $error("write strobe not placed on second tap C rise");

	// structural checks on the registered strobes
	idle_quiet_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(state == dram_timing_pkg::S_IDLE) |-> (o_ras_n && o_row_col_select &&
			o_col_strobe_common_n && o_cas_n == dram_timing_pkg::CAS_IDLE && o_oe_n && o_we_n))
		else $error("strobe active while sequencer idle");

	cas_needs_ras_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(o_cas_n != dram_timing_pkg::CAS_IDLE) |-> !o_ras_n)
		else $error("column strobe without row strobe");

	one_plane_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		$onehot0(~o_cas_n))
		else $error("more than one column strobe active");

	oe_one_row_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		!o_oe_n |-> $onehot(~o_cas_n))
		else $error("output enable without exactly one selected row");

	cas_col_addr_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		!o_col_strobe_common_n |-> !o_row_col_select)
		else $error("column strobe while row address selected");

	col_addr_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		!o_row_col_select |-> (o_mem_addr == {2'b00, bus_lat[13:8]}))
		else $error("column address does not match latched bus");

	// the low address bits are the refresh address, so the row must be exact
	row_addr_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(!o_ras_n && o_row_col_select) |-> (o_mem_addr == bus_lat[7:0]))
		else $error("row address does not match latched bus");

	ale_ends_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		(state != dram_timing_pkg::S_IDLE && i_ale) |=> (state == dram_timing_pkg::S_IDLE))
		else $error("sequencer not idle after latch strobe rise");

	// the first edge after reset repeats the reset count, so it is skipped
	divider_step_a: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
		!$past(i_sys_rst) |-> (tap == DIV_WIDTH'($past(tap) + 1'b1)))
		else $error("dot clock divider did not count by one");

endmodule
`default_nettype wire

// *** core/dram_timing_pkg.sv ***
// Purpose: shared constants for the graphics memory timing sequencer
// Assumes: the system clock stands in for the dot clock
// Notes:   tap positions pick divider outputs that place the column address, column strobe, output enable and write strobe edges
package dram_timing_pkg;

	// clock
	localparam int unsigned CLK_PERIOD_NS = 40;

	// divider
	localparam int unsigned DIV_WIDTH     = 3;
	localparam logic [2:0]  DIV_RST       = 3'h0;
	localparam int unsigned TAP_A         = 0;
	localparam int unsigned TAP_C         = 1;
	localparam int unsigned TAP_WORD      = 2;

	// multiplexed bus fields
	localparam int unsigned BUS_WIDTH     = 16;
	localparam int unsigned ROW_LSB       = 0;
	localparam int unsigned ROW_MSB       = 7;
	localparam int unsigned COL_LSB       = 8;
	localparam int unsigned COL_MSB       = 13;
	localparam int unsigned SEL_LSB       = 14;
	localparam int unsigned SEL_MSB       = 15;
	localparam int unsigned ADDR_WIDTH    = 8;
	localparam int unsigned NUM_ROWS      = 4;

	// write strobe delay in tap C periods
	localparam int unsigned WE_DELAY      = 2;

	// reset values
	localparam logic [15:0] BUS_RST       = 16'h0000;
	localparam logic [7:0]  ADDR_RST      = 8'h00;
	localparam logic [3:0]  CAS_IDLE      = 4'hF;

	typedef enum logic [4:0] {
		S_IDLE = 5'b00001,
		S_ROW  = 5'b00010,
		S_COL  = 5'b00100,
		S_CAS  = 5'b01000,
		S_DATA = 5'b10000
	} seq_state_e;

endpackage

// *** core/dot_divider.sv ***
// Purpose: free running binary divider of the dot clock with tap rise pulses
// Assumes: synchronous active high reset
// Notes:   the pulse marks the first cycle that a tap is high
`timescale 1ns/100ps
`default_nettype none
module dot_divider #(
	parameter int unsigned WIDTH = dram_timing_pkg::DIV_WIDTH
) (
	// clock and reset
	input  wire logic             i_sys_clk,
	input  wire logic             i_sys_rst,
	// taps
	output logic [WIDTH-1:0]      o_tap,
	output logic [WIDTH-1:0]      o_tap_rise
);

	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] prev;
	logic [WIDTH-1:0] next_count;
	logic [WIDTH-1:0] next_prev;

	function automatic logic [WIDTH-1:0] rose(input logic [WIDTH-1:0] cur,
			input logic [WIDTH-1:0] old);
		rose = cur & ~old;
	endfunction

	always_comb begin
		next_count = count + WIDTH'(1);
		next_prev  = count;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_sys_rst) begin
			count <= WIDTH'(dram_timing_pkg::DIV_RST);
			prev  <= WIDTH'(dram_timing_pkg::DIV_RST);
		end else begin
			count <= next_count;
			prev  <= next_prev;
		end
	end

	assign o_tap      = count;
	assign o_tap_rise = rose(count, prev);

endmodule
`default_nettype wire

// *** verification/disp_ctrl_model.sv ***
// Purpose: display controller stand-in driving latch strobe, bus, read gate and blank
// Assumes: requests change just after a rising edge, by non-blocking assignment
// Notes:   a released bus shows the inverse of the last address, not a stale copy
`timescale 1ns/100ps
`default_nettype none
module disp_ctrl_model (
	// clock
	input  wire logic   i_sys_clk,
	// controller pins
	output logic        o_ale,
	output logic [15:0] o_ad,
	output logic        o_read_gate_n,
	output logic        o_video_off
);
	initial begin
		o_ale         = 1'b1;
		o_ad          = 16'h0000;
		o_read_gate_n = 1'b1;
		o_video_off   = 1'b0;
	end

	// kind: 0 display, 1 refresh, 2 read-modify-write; len plus one cycles with the strobe low
	task automatic access(input logic [15:0] a, input int kind, input int len);
		@(posedge i_sys_clk);
		o_ale       <= 1'b0;
		o_ad        <= a;
		o_video_off <= (kind != 0);
		for (int i = 0; i < len; i++) begin
			@(posedge i_sys_clk);
			o_read_gate_n <= !(kind == 2 && i >= 3 && i < 18);
		end
		@(posedge i_sys_clk);
		o_ale         <= 1'b1;
		o_ad          <= ~a;
		o_read_gate_n <= 1'b1;
		// strobe stays high between cycles, as a slow word clock would
		repeat (2) @(posedge i_sys_clk);
	endtask
endmodule
`default_nettype wire

// *** verification/graphics_dram_timing_ctrl_tb.sv ***
// Purpose: self-checking bench for the graphics memory timing sequencer
// Assumes: cycle model follows the registered strobe timing of the hand-over
// Notes:   outputs compared with the model on every falling edge out of reset, address only while row strobe expected low
`timescale 1ns/100ps
`default_nettype none
module graphics_dram_timing_ctrl_tb;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	wire logic ale, rg, vo;
	wire logic [15:0] ad;
	logic ras_n, rcs, csc_n, oe_n, we_n;
	logic [7:0] addr;
	logic [3:0] cas_n;
	int n_errors = 0;
	int comparisons = 0;
	logic [31:0] seed = 32'h587b_8abe;
	// model state
	logic [2:0] cnt, pcnt;
	logic [15:0] lat;
	logic pa, pc, pw, alep, seen, off, s1, s2;
	logic e_ras, e_rcs, e_csc, e_oe, e_we;
	logic [7:0] e_addr;
	logic [3:0] e_cas;
	int st;

	always #20 sys_clk = ~sys_clk;

	disp_ctrl_model i_disp_ctrl_model (.i_sys_clk(sys_clk), .o_ale(ale), .o_ad(ad),
		.o_read_gate_n(rg), .o_video_off(vo));

	graphics_dram_timing_ctrl i_graphics_dram_timing_ctrl (.i_sys_clk(sys_clk),
		.i_sys_rst(sys_rst), .i_ale(ale), .i_ad(ad), .i_read_gate_n(rg), .i_video_off(vo),
		.o_ras_n(ras_n), .o_row_col_select(rcs), .o_mem_addr(addr),
		.o_col_strobe_common_n(csc_n), .o_cas_n(cas_n), .o_oe_n(oe_n), .o_we_n(we_n));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		s = s ^ (s << 5);
		return s;
	endfunction

	task automatic chk(input string name, input logic [7:0] seen_v, input logic [7:0] exp_v);
		comparisons++;
		if (seen_v !== exp_v) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", name, exp_v, seen_v);
		end
	endtask

	always @(posedge sys_clk) begin
		pa = cnt[0] & ~pcnt[0];
		pc = cnt[1] & ~pcnt[1];
		pw = cnt[2] & ~pcnt[2];
		if (sys_rst || ale) begin
			if (sys_rst) begin
				cnt = 3'h0;
				pcnt = 3'h0;
				e_addr = 8'h00;
			end else begin
				pcnt = cnt;
				cnt = cnt + 3'h1;
			end
			{e_ras, e_rcs, e_csc, e_oe, e_cas} = {4'hF, 4'hF};
			{st, seen, off, s1, s2} = '0;
			alep = 1'b1;
		end else begin
			pcnt = cnt;
			cnt = cnt + 3'h1;
			if (st > 0) begin
				off = off | (seen & rg);
				seen = seen | !rg;
				if (pc) begin
					s2 = s1;
					s1 = seen;
				end
			end
			case (st)
				0: if (alep) begin
					e_ras = 1'b0;
					e_addr = ad[7:0];
					lat = ad;
					st = 1;
				end
				1: if (pw) begin
					e_rcs = 1'b0;
					e_addr = {2'b00, lat[13:8]};
					st = 2;
				end
				2: if (pa) begin
					e_csc = 1'b0;
					e_cas[lat[15:14]] = 1'b0;
					st = 3;
				end
				3: if (pc) begin
					e_oe = !((!vo || !rg) && !off);
					st = 4;
				end
				default: e_oe = !((!vo || !rg) && !off);
			endcase
			alep = 1'b0;
		end
		e_we = !s2;
	end

	always @(negedge sys_clk) begin
		if (!sys_rst) begin
			chk("row strobe", {7'h0, ras_n}, {7'h0, e_ras});
			chk("row col select", {7'h0, rcs}, {7'h0, e_rcs});
			chk("common col strobe", {7'h0, csc_n}, {7'h0, e_csc});
			chk("col strobes", {4'h0, cas_n}, {4'h0, e_cas});
			chk("output enable", {7'h0, oe_n}, {7'h0, e_oe});
			chk("write strobe", {7'h0, we_n}, {7'h0, e_we});
			if (!e_ras)
				chk("memory address", addr, e_addr);
		end
	end

	task automatic results;
		$display("comparisons %0d errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial begin
		repeat (5000) @(posedge sys_clk);
		n_errors++;
		results;
	end

	initial begin
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		// short cycles end mid-sequence; bits 15:14 walk all four rows
		for (int i = 0; i < 24; i++) begin
			seed = xs(seed);
			i_disp_ctrl_model.access({i[1:0], seed[13:0]}, i % 3, (i % 4 == 3) ? 5 : 34);
		end
		results;
	end
endmodule
`default_nettype wire
